// >>> hdl/status_led_pkg.sv
package status_led_pkg;
	timeunit 1ns;
	timeprecision 1ns;

	// Clock and base timing
	localparam int unsigned CLK_HZ           = 20000000;   // System clock rate
	localparam int unsigned BASE_ON_TIME_US  = 62500;      // Shortest on time, 62.5 ms
	localparam int unsigned BASE_TICK_CYCLES = (CLK_HZ / 1000000) * BASE_ON_TIME_US;

	// Counter widths
	localparam int DIV_W   = 21;                           // Holds BASE_TICK_CYCLES - 1
	localparam int CNT_W   = 7;                            // Holds the longest off phase in ticks
	localparam int PULSE_W = 3;                            // Holds up to 7 pulses

	// Register indices and byte addresses (index times four)
	localparam logic [15:0] CTRL_ONE_IDX  = 16'h404C;
	localparam logic [15:0] CTRL_TWO_IDX  = 16'h404D;
	localparam logic [15:0] STATUS_IDX    = 16'h404E;
	localparam logic [31:0] CTRL_ONE_ADDR = {14'h0000, CTRL_ONE_IDX, 2'h0};
	localparam logic [31:0] CTRL_TWO_ADDR = {14'h0000, CTRL_TWO_IDX, 2'h0};
	localparam logic [31:0] STATUS_ADDR   = {14'h0000, STATUS_IDX, 2'h0};

	// Control register field positions
	localparam int SRC_LSB   = 14;
	localparam int MODE_LSB  = 8;
	localparam int LEN_LSB   = 4;
	localparam int DUR_LSB   = 2;
	localparam int RATIO_LSB = 0;

	// Control register reset value and writable bits
	localparam logic [15:0] CTRL_RESET = 16'hC026;
	localparam logic [15:0] CTRL_WMASK = 16'hC33F;

	// Status register bit positions
	localparam int ST_LED_LSB   = 0;
	localparam int ST_OTP_DONE  = 2;
	localparam int ST_OTP_ERR   = 3;
	localparam int ST_FAIL      = 4;
	localparam int ST_SUPPLY_LO = 5;

	// Function select encoding
	typedef enum logic [1:0] {
		SRC_OFF    = 2'h0,
		SRC_STATUS = 2'h1,
		SRC_RSVD   = 2'h2,
		SRC_MANUAL = 2'h3
	} src_t;

	// Pattern kinds, same coding as the manual pattern select field
	typedef enum logic [1:0] {
		KIND_OFF   = 2'h0,
		KIND_CONST = 2'h1,
		KIND_CONT  = 2'h2,
		KIND_SEQ   = 2'h3
	} kind_t;

	// Field codes used by the power-state patterns
	localparam logic [1:0] DUR_1S    = 2'h0;
	localparam logic [1:0] DUR_250MS = 2'h1;
	localparam logic [1:0] RATIO_1_1 = 2'h0;
	localparam logic [1:0] RATIO_1_3 = 2'h2;
	localparam logic [1:0] RATIO_1_7 = 2'h3;
	localparam logic [1:0] LEN_4     = 2'h2;

	// On time per code, in base ticks
	localparam logic [CNT_W-1:0] ON_TICKS_1S    = 7'h10;
	localparam logic [CNT_W-1:0] ON_TICKS_250MS = 7'h04;
	localparam logic [CNT_W-1:0] ON_TICKS_125MS = 7'h02;
	localparam logic [CNT_W-1:0] ON_TICKS_62MS  = 7'h01;

	// Pulse counts per code
	localparam logic [PULSE_W-1:0] LEN_ONE   = 3'h1;
	localparam logic [PULSE_W-1:0] LEN_TWO   = 3'h2;
	localparam logic [PULSE_W-1:0] LEN_FOUR  = 3'h4;
	localparam logic [PULSE_W-1:0] LEN_SEVEN = 3'h7;

	// Pattern phases
	typedef enum logic [3:0] {
		PH_IDLE = 4'h1,
		PH_ON   = 4'h2,
		PH_OFF  = 4'h4,
		PH_DONE = 4'h8
	} phase_t;

endpackage : status_led_pkg

// >>> hdl/led_pattern_gen.sv
module led_pattern_gen #(
	parameter int unsigned TICK_CYCLES = status_led_pkg::BASE_TICK_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       sys_rst,
	input  wire logic       restart,    // Pattern changed, start again
	input  wire logic [1:0] kind,       // Off, constant, continuous, sequence
	input  wire logic [1:0] on_sel,     // On time code
	input  wire logic [1:0] ratio_sel,  // On:off ratio code
	input  wire logic [1:0] len_sel,    // Pulse count code
	output logic            led,        // Registered drive level
	output logic            seq_done    // One-cycle pulse after the last pulse
);
	timeunit 1ns;
	timeprecision 1ns;

	localparam int CW = status_led_pkg::CNT_W;
	localparam int PW = status_led_pkg::PULSE_W;

	status_led_pkg::phase_t      phase_r;    // Current phase
	status_led_pkg::phase_t      phase_nxt;  // Next phase
	logic [status_led_pkg::DIV_W-1:0] div_r; // Base tick divider
	logic [CW-1:0]               cnt_r;      // Ticks spent in phase
	logic [PW-1:0]               pulses_r;   // Pulses emitted so far
	logic                        led_r;      // Output flop
	logic                        done_r;     // Sequence end pulse

	wire pulsed = (kind == status_led_pkg::KIND_CONT) | (kind == status_led_pkg::KIND_SEQ);
	wire tick   = (div_r == status_led_pkg::DIV_W'(TICK_CYCLES - 1));

	// On time in ticks
	wire [CW-1:0] on_ticks = (on_sel == 2'h0) ? status_led_pkg::ON_TICKS_1S :
	                         (on_sel == 2'h1) ? status_led_pkg::ON_TICKS_250MS :
	                         (on_sel == 2'h2) ? status_led_pkg::ON_TICKS_125MS :
	                                            status_led_pkg::ON_TICKS_62MS;
	// Off time is the on time times 1, 2, 3 or 7
	wire [CW-1:0] off_ticks = (ratio_sel == 2'h0) ? on_ticks :
	                          (ratio_sel == 2'h1) ? CW'({on_ticks, 1'b0}) :
	                          (ratio_sel == 2'h2) ? CW'({on_ticks, 1'b0} + on_ticks) :
	                                                CW'({on_ticks, 3'h0} - on_ticks);
	// Pulses in a sequence
	wire [PW-1:0] len = (len_sel == 2'h0) ? status_led_pkg::LEN_ONE :
	                    (len_sel == 2'h1) ? status_led_pkg::LEN_TWO :
	                    (len_sel == 2'h2) ? status_led_pkg::LEN_FOUR :
	                                        status_led_pkg::LEN_SEVEN;

	// Ends are qualified by phase; otherwise the on-time compare would also
	// fire part way through a longer off phase and restart its count
	wire on_end    = tick & (phase_r == status_led_pkg::PH_ON) & (cnt_r == on_ticks - 1'b1);
	wire off_end   = tick & (phase_r == status_led_pkg::PH_OFF) & (cnt_r == off_ticks - 1'b1);
	wire last_one  = (kind == status_led_pkg::KIND_SEQ) & (pulses_r + 1'b1 == len);

	// Phase sequencing
	always_comb begin
		phase_nxt = phase_r;
		case (phase_r)
			status_led_pkg::PH_IDLE: phase_nxt = phase_r;
			status_led_pkg::PH_ON:   if (on_end) begin
				phase_nxt = last_one ? status_led_pkg::PH_DONE : status_led_pkg::PH_OFF;
			end
			status_led_pkg::PH_OFF:  if (off_end) begin
				phase_nxt = status_led_pkg::PH_ON;
			end
			status_led_pkg::PH_DONE: phase_nxt = phase_r;
			default:                 phase_nxt = status_led_pkg::PH_IDLE;
		endcase
		// Any change starts a fresh on period for pulsed kinds, else idle, with the divider cleared
		if (restart) begin
			phase_nxt = pulsed ? status_led_pkg::PH_ON : status_led_pkg::PH_IDLE;
		end
	end

	// Divider, phase counters and output; the divider restarts too so the
	// first on period is never cut short by a stale tick phase
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			phase_r  <= status_led_pkg::PH_IDLE;
			div_r    <= '0;
			cnt_r    <= '0;
			pulses_r <= '0;
			led_r    <= 1'b0;
			done_r   <= 1'b0;
		end else begin
			phase_r  <= phase_nxt;
			div_r    <= (restart | tick) ? '0 : div_r + 1'b1;
			cnt_r    <= (restart | on_end | off_end) ? '0 : (tick ? cnt_r + 1'b1 : cnt_r);
			pulses_r <= restart ? '0 : (on_end ? pulses_r + 1'b1 : pulses_r);
			done_r   <= ~restart & (phase_r == status_led_pkg::PH_ON) & on_end & last_one;
			led_r    <= (kind == status_led_pkg::KIND_CONST) |
			            (pulsed & (phase_nxt == status_led_pkg::PH_ON));
		end
	end

	assign led      = led_r;
	assign seq_done = done_r;

endmodule : led_pattern_gen

// >>> hdl/status_led_pattern_driver.sv
// The implementer's own choice: the APB slave port.
module status_led_pattern_driver #(
	parameter int unsigned TICK_CYCLES = status_led_pkg::BASE_TICK_CYCLES
) (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Power state and events from the device core
	input  wire logic        power_on_state,
	input  wire logic        power_sleep_state,
	input  wire logic        supply_low_raw,
	input  wire logic        seq_fail_event,
	input  wire logic        otp_prog_complete,
	input  wire logic        otp_prog_error,
	// Outputs
	output logic      [1:0]  led_drive,
	output logic             off_release
);
	timeunit 1ns;
	timeprecision 1ns;

	// How the block fits together
	// Each output owns a 16-bit control word reached over APB. Its function
	// select picks off, power-state indication, a reserved code that acts as
	// off, or manual patterns. This module only decides which pattern each
	// output should show; timing is left to one pattern engine per output.
	//
	// A pattern is a kind (dark, steady, endless pulses, counted pulses),
	// an on time, an on:off ratio and a pulse count. The engine counts base
	// ticks of 62.5 ms, so 1 s is sixteen ticks and 250 ms is four.
	//
	// Precedence, highest first:
	//   programming result of that output, steady on until reset
	//   failure sequence, for outputs in power-state mode
	//   outside ON and SLEEP, everything else is dark
	//   supply low, then ON, then SLEEP, for power-state outputs
	//   the manual fields, for outputs in manual mode
	//
	// Latency, counted from the edge that changes the choice: cfg_w differs
	// from cfg_prev_r at once, so only the engine's output flop adds an edge. A
	// register write thus reaches the pin one cycle after its access edge;
	// the supply-low input adds two cycles for its synchroniser.
	//
	// Register map; the byte address is four times the register index:
	//   first control word, second control word, read-only status word.
	// Control word fields:
	//   [15:14] function select, [9:8] manual pattern select,
	//   [5:4] pulse count select, [3:2] pulse on time select,
	//   [1:0] on:off ratio select; all other bits read as zero.
	// Status word fields:
	//   [1:0] output levels, [2] programming done, [3] programming error,
	//   [4] failure pending, [5] supply low after synchronising.
	//
	// Limitation: the failure sequence goes on after the core has left ON,
	// or it could never finish. The core has to wait for off_release before
	// it removes power from the outputs.
	//
	// Trade-off: any change of the chosen pattern restarts it, a change of
	// on time alone too. No half-shown pulse leaks into the new pattern, at
	// the price of restarting a rhythm that may look the same.
	//
	// Single clock: every slow rate comes from the tick divider inside each
	// engine, which restarts together with its pattern.

	// Control registers, one per output
	logic [15:0] ctrl_r [2];
	// Captured read data
	logic [31:0] prdata_r;
	// Supply-low synchroniser
	logic        low_meta_r;
	logic        low_sync_r;
	// Programming result latches
	logic        otp_done_r;
	logic        otp_err_r;
	// Failure sequence pending
	logic        fail_r;
	// Outputs that finished the failure sequence
	logic [1:0]  fail_done_r;
	// Release pulse flop
	logic        release_r;

	// Per-output signals from the generate loop
	logic [1:0]  led_w;
	logic [1:0]  seq_done_w;
	logic [1:0]  fail_shown_w;

	// APB phase decode
	wire apb_setup  = psel & ~penable;
	wire apb_access = psel & penable;
	wire apb_write  = apb_access & pwrite;

	// Address decode
	// Full 32-bit compares, so no register has an alias elsewhere
	wire hit_one    = (paddr == status_led_pkg::CTRL_ONE_ADDR);
	wire hit_two    = (paddr == status_led_pkg::CTRL_TWO_ADDR);
	wire hit_status = (paddr == status_led_pkg::STATUS_ADDR);
	wire hit_any    = hit_one | hit_two | hit_status;

	// Byte lanes that a write may touch
	// Reserved bits are masked out, so they always read back as zero
	wire [15:0] lane_mask = status_led_pkg::CTRL_WMASK & {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Status word shows the block's own state
	wire [15:0] status_word = {10'h000, low_sync_r, fail_r, otp_err_r, otp_done_r, led_w};

	// Read mux selected by address
	wire [15:0] rd_sel = hit_one    ? ctrl_r[0] :
	                     hit_two    ? ctrl_r[1] :
	                     hit_status ? status_word :
	                                  16'h0000;

	// Device is in a state where the outputs are configurable
	// Either state lets the configured functions act
	wire pwr_active = power_on_state | power_sleep_state;

	// Release towards OFF once every output showing the failure has finished
	// Done bits of an earlier failure are cleared together with the release
	wire release_now = fail_r & (&(fail_done_r | seq_done_w | ~fail_shown_w));

	// Loading the read flop at the end of setup means no wait state is ever
	// needed. A master that changed paddr between setup and access would
	// read the word named in setup; the bus protocol forbids such a change.
	// pready is therefore tied high.
	// Read data is taken in the setup cycle so it sits in a flop by the access cycle
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			prdata_r <= 32'h0000_0000;
		end else if (apb_setup) begin
			prdata_r <= {16'h0000, rd_sel};
		end
	end

	// The slave never waits, so the access phase is always one cycle
	assign pready  = 1'b1;
	// Unmapped addresses and writes to the status word are errors
	// pstrb[3:2] and pwdata[31:16] are ignored: every register is 16 bits
	assign pslverr = apb_access & (~hit_any | (pwrite & hit_status));
	assign prdata  = prdata_r;

	// Two-flop synchroniser; the comparator output is asynchronous to clk
	// Only low_sync_r may be read; the first flop can be metastable.
	// The two cycles of lag are far below one base tick.
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			low_meta_r <= 1'b0;
			low_sync_r <= 1'b0;
		end else begin
			low_meta_r <= supply_low_raw;
			low_sync_r <= low_meta_r;
		end
	end

	// Programming results latch and only a device reset clears them
	// A result pulse in a reset cycle is lost, as the reset must win
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			otp_done_r <= 1'b0;
			otp_err_r  <= 1'b0;
		end else begin
			otp_done_r <= otp_done_r | otp_prog_complete;
			otp_err_r  <= otp_err_r | otp_prog_error;
		end
	end

	// Each output showing the failure raises seq_done once. The pulses may
	// come in different cycles if one output started its sequence later, so
	// they are collected in fail_done_r until every showing output is done.
	// An output that does not show the failure never holds up the release.
	// Set wins over release, so a failure in the release cycle is kept.
	// Failure pending; a new event in the release cycle keeps it set
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			fail_r      <= 1'b0;
			fail_done_r <= 2'h0;
			release_r   <= 1'b0;
		end else begin
			fail_r      <= seq_fail_event | (fail_r & ~release_now);
			fail_done_r <= release_now ? 2'h0 : (fail_done_r | (seq_done_w & fail_shown_w));
			release_r   <= release_now;
		end
	end

	// OFF transition may proceed only after the pulses were emitted
	assign off_release = release_r;

	// Both outputs share this code; only the register address and the programming
	// result that forces them differ: success on the first, error on the second.
	// One identical channel per output
	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_out
			// Register write value
			logic [15:0] ctrl_nxt;
			// Pattern configuration and its previous value
			logic [7:0]  cfg_w;
			logic [7:0]  cfg_prev_r;

			wire sel_hit = (i == 0) ? hit_one : hit_two;

			// Only the documented fields are writable, reserved bits stay zero
			assign ctrl_nxt = (ctrl_r[i] & ~lane_mask) | (pwdata[15:0] & lane_mask);

			// Control register, written at the access edge
			// A refused access never gets here, as sel_hit covers control words only
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					ctrl_r[i] <= status_led_pkg::CTRL_RESET;
				end else if (apb_write & sel_hit) begin
					ctrl_r[i] <= ctrl_nxt;
				end
			end

			// Field extraction
			// Positions come from the package so the tests share them
			wire [1:0] src   = ctrl_r[i][status_led_pkg::SRC_LSB +: 2];
			wire [1:0] mode  = ctrl_r[i][status_led_pkg::MODE_LSB +: 2];
			wire [1:0] len   = ctrl_r[i][status_led_pkg::LEN_LSB +: 2];
			wire [1:0] dur   = ctrl_r[i][status_led_pkg::DUR_LSB +: 2];
			wire [1:0] ratio = ctrl_r[i][status_led_pkg::RATIO_LSB +: 2];

			// Programming result belonging to this output
			wire otp_force = (i == 0) ? otp_done_r : otp_err_r;
			wire st_sel    = (src == status_led_pkg::SRC_STATUS);
			wire man_sel   = (src == status_led_pkg::SRC_MANUAL);

			// Failure is shown even as the state leaves ON, so the
			// pulses can finish before the move to OFF
			assign fail_shown_w[i] = ~otp_force & st_sel & fail_r;

			// Layout of cfg_w: [7:6] kind, [5:4] on time, [3:2] ratio, [1:0] count.
			// It matches the manual fields' codes, so manual mode is a straight
			// copy and the engine decodes one format only.
			// Pattern choice in priority order; off and reserved fall to off
			assign cfg_w =
				otp_force ? {status_led_pkg::KIND_CONST, 6'h00} :
				fail_shown_w[i] ? {status_led_pkg::KIND_SEQ, status_led_pkg::DUR_1S,
				                   status_led_pkg::RATIO_1_1, status_led_pkg::LEN_4} :
				~pwr_active ? {status_led_pkg::KIND_OFF, 6'h00} :
				(st_sel & low_sync_r) ? {status_led_pkg::KIND_CONT, status_led_pkg::DUR_250MS,
				                         status_led_pkg::RATIO_1_3, 2'h0} :
				(st_sel & power_on_state) ? {status_led_pkg::KIND_CONST, 6'h00} :
				st_sel ? {status_led_pkg::KIND_CONT, status_led_pkg::DUR_250MS,
				          status_led_pkg::RATIO_1_7, 2'h0} :
				man_sel ? {mode, dur, ratio, len} :
				          {status_led_pkg::KIND_OFF, 6'h00};

			// Previous configuration, to spot any change
			// A change of power state, supply level or register all look alike
			// here; each that alters cfg_w gives one restart strobe
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					cfg_prev_r <= 8'h00;
				end else begin
					cfg_prev_r <= cfg_w;
				end
			end

			// Pattern engine for this output
			led_pattern_gen #(
				.TICK_CYCLES (TICK_CYCLES)
			) u_gen (
				.clk       (clk),
				.sys_rst   (sys_rst),
				.restart   (cfg_w != cfg_prev_r),
				.kind      (cfg_w[7:6]),
				.on_sel    (cfg_w[5:4]),
				.ratio_sel (cfg_w[3:2]),
				.len_sel   (cfg_w[1:0]),
				.led       (led_w[i]),
				.seq_done  (seq_done_w[i])
			);
		end
	endgenerate

	// Drive pins straight from the pattern flops
	// No extra flop: the engine already registers its output, and a second
	// stage would only add a cycle of lag
	assign led_drive = led_w;

endmodule : status_led_pattern_driver

// >>> tb/status_led_props.sv
module status_led_props (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        otp_prog_complete,
	input wire logic        otp_prog_error,
	input wire logic [1:0]  led_drive,
	input wire logic        off_release
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);

	// Access phase of any transfer
	wire access = psel && penable;
	// One of the three decoded places
	wire mapped = paddr == status_led_pkg::CTRL_ONE_ADDR || paddr == status_led_pkg::CTRL_TWO_ADDR
		|| paddr == status_led_pkg::STATUS_ADDR;

	a_otp_first_on: assert property (otp_prog_complete |-> ##2 led_drive[0] [*8])
		else $error("first output dark after programming success");
	a_otp_second_on: assert property (otp_prog_error |-> ##2 led_drive[1] [*8])
		else $error("second output dark after programming error");
	a_reset_dark: assert property (disable iff (1'b0) sys_rst |=> led_drive == 2'h0)
		else $error("outputs lit after reset");
	a_release_pulse: assert property (off_release |=> !off_release)
		else $error("release longer than one cycle");
	a_unmapped_err: assert property (access && !mapped |-> pslverr && prdata == 32'h0)
		else $error("unmapped access not refused");
	a_ctrl_no_err: assert property (access && paddr == status_led_pkg::CTRL_ONE_ADDR |-> !pslverr)
		else $error("control access refused");
	a_upper_zero: assert property (access |-> prdata[31:16] == 16'h0000 ##1 $stable(prdata))
		else $error("read data upper half or stability wrong");
	a_ready_high: assert property (pready)
		else $error("ready low");

	// Main scenarios
	c_release: cover property (off_release);
	c_refused: cover property (access && pslverr);
	c_second_lit: cover property ($rose(led_drive[1]));
endmodule : status_led_props

// >>> tb/led_lamp_model.sv
module led_lamp_model (
	input wire logic        clk,
	input wire logic        level,   // Pin level seen by the lamp
	output logic     [31:0] hi_len,  // Length of last lit run, in cycles
	output logic     [31:0] lo_len   // Length of last dark run, in cycles
);
	timeunit 1ns;
	timeprecision 1ns;
	logic        prev = 1'b0;  // Level at the previous edge
	logic [31:0] run  = 32'h0; // Cycles in the current run

	// The lamp has no memory beyond run lengths, so it cannot mask a glitch
	always @(posedge clk) begin
		if (level !== prev) begin
			if (prev)
				hi_len <= run;
			else
				lo_len <= run;
			run <= 32'h1;
		end else begin
			run <= run + 32'h1;
		end
		prev <= level;
	end
endmodule : led_lamp_model

// >>> tb/status_led_pattern_driver_tb.sv
module status_led_pattern_driver_tb;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [15:0] ctrl;
		logic        on;
		logic        slp;
		logic        low;
		logic [7:0]  hi;   // Lit run, zero for a steady level
		logic [7:0]  lo;   // Dark run, or the steady level
	} row_t;
	// Four clocks per tick: 1s = 64, 250ms = 16, 125ms = 8, 62.5ms = 4 cycles
	localparam row_t ROWS [12] = '{
		'{16'hC200, 1'b1, 1'b0, 1'b0, 8'h40, 8'h40}, '{16'hC205, 1'b1, 1'b0, 1'b0, 8'h10, 8'h20},
		'{16'hC20A, 1'b1, 1'b0, 1'b0, 8'h08, 8'h18}, '{16'hC20F, 1'b1, 1'b0, 1'b0, 8'h04, 8'h1C},
		'{16'h4000, 1'b0, 1'b1, 1'b0, 8'h10, 8'h70}, '{16'h4000, 1'b1, 1'b0, 1'b1, 8'h10, 8'h30},
		'{16'h4000, 1'b1, 1'b0, 1'b0, 8'h00, 8'h01}, '{16'hC100, 1'b1, 1'b0, 1'b0, 8'h00, 8'h01},
		'{16'h0000, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00}, '{16'h8100, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00},
		'{16'hC100, 1'b0, 1'b0, 1'b0, 8'h00, 8'h00}, '{16'hC000, 1'b1, 1'b0, 1'b0, 8'h00, 8'h00}};
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        on_st = 1'b0;
	logic        slp_st = 1'b0;
	logic        low = 1'b0;
	logic        fail = 1'b0;
	logic        done = 1'b0;
	logic        err = 1'b0;
	logic [1:0]  led_drive;
	logic        off_release;
	logic [31:0] lamp_hi;
	logic [31:0] lamp_lo;
	logic [31:0] rd;
	logic        er;
	int          fails = 0;
	int          n_compared = 0;
	int          rises;
	int          rels;

	status_led_pattern_driver #(.TICK_CYCLES(4)) dut_u (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.power_on_state(on_st), .power_sleep_state(slp_st), .supply_low_raw(low),
		.seq_fail_event(fail), .otp_prog_complete(done), .otp_prog_error(err),
		.led_drive(led_drive), .off_release(off_release));
	led_lamp_model lamp_u (.clk(clk), .level(led_drive[0]), .hi_len(lamp_hi), .lo_len(lamp_lo));

	// 50 ns period
	initial begin
		forever #25 clk = ~clk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1) @(posedge clk);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic reset_dut;
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (10) @(posedge clk);
		sys_rst <= 1'b0;
	endtask : reset_dut

	// Counts rising edges of the first output and release pulses
	task automatic watch(input int n);
		logic prev;
		prev = led_drive[0];
		rises = 0;
		rels = 0;
		repeat (n) begin
			@(negedge clk);
			rises += (led_drive[0] === 1'b1 && prev === 1'b0);
			rels += (off_release === 1'b1);
			prev = led_drive[0];
		end
	endtask : watch

	task automatic summarize;
		$display("compared %0d, fails %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize

	// Hang guard, well above the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		summarize();
	end

	initial begin
		reset_dut();
		for (int i = 0; i < 12; i++) begin
			@(posedge clk);
			on_st <= ROWS[i].on;
			slp_st <= ROWS[i].slp;
			low <= ROWS[i].low;
			apb(1'b1, status_led_pkg::CTRL_ONE_ADDR, {16'h0000, ROWS[i].ctrl}, rd, er);
			if (ROWS[i].hi == 8'h00) begin
				repeat (12) @(negedge clk);
				chk(led_drive[0], ROWS[i].lo[0]);
			end else begin
				repeat (2 * (ROWS[i].hi + ROWS[i].lo) + 8) @(negedge clk);
				chk(lamp_hi, ROWS[i].hi);
				chk(lamp_lo, ROWS[i].lo);
			end
			chk(led_drive[1], 1'b0);
		end
		// Single pulse, then seven, each ending dark
		apb(1'b1, status_led_pkg::CTRL_ONE_ADDR, 32'h0000C30C, rd, er);
		watch(100);
		chk(rises, 1);
		apb(1'b1, status_led_pkg::CTRL_ONE_ADDR, 32'h0000C33C, rd, er);
		watch(100);
		chk(rises, 7);
		chk(led_drive[0], 1'b0);
		// Failure outside ON/SLEEP while supply is low
		@(posedge clk);
		on_st <= 1'b0;
		low <= 1'b1;
		apb(1'b1, status_led_pkg::CTRL_ONE_ADDR, 32'h00004000, rd, er);
		apb(1'b1, status_led_pkg::CTRL_TWO_ADDR, 32'h00004000, rd, er);
		fail <= 1'b1;
		@(posedge clk);
		fail <= 1'b0;
		watch(560);
		chk(rises, 4);
		chk(rels, 1);
		chk(lamp_hi, 32'h40);
		chk(led_drive, 2'h0);
		// Programming results override the off selection
		apb(1'b1, status_led_pkg::CTRL_ONE_ADDR, 32'h0, rd, er);
		apb(1'b1, status_led_pkg::CTRL_TWO_ADDR, 32'h0, rd, er);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		repeat (4) @(negedge clk);
		chk(led_drive, 2'h1);
		@(posedge clk);
		err <= 1'b1;
		@(posedge clk);
		err <= 1'b0;
		repeat (4) @(negedge clk);
		chk(led_drive, 2'h3);
		// Status: supply low, both results latched, both outputs lit
		apb(1'b0, status_led_pkg::STATUS_ADDR, 32'h0, rd, er);
		chk(rd, 32'h0000002F);
		reset_dut();
		@(negedge clk);
		chk(led_drive, 2'h0);
		apb(1'b0, status_led_pkg::CTRL_ONE_ADDR, 32'h0, rd, er);
		chk(rd, 32'h0000C026);
		apb(1'b0, status_led_pkg::CTRL_TWO_ADDR, 32'h0, rd, er);
		chk(rd, 32'h0000C026);
		apb(1'b0, 32'h00000010, 32'h0, rd, er);
		chk({rd[30:0], er}, 32'h1);
		apb(1'b1, status_led_pkg::STATUS_ADDR, 32'hFFFF, rd, er);
		chk(er, 1'b1);
		summarize();
	end
endmodule : status_led_pattern_driver_tb

bind status_led_pattern_driver status_led_props props_u (.clk(clk), .sys_rst(sys_rst),
	.psel(psel), .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .otp_prog_complete(otp_prog_complete), .otp_prog_error(otp_prog_error),
	.led_drive(led_drive), .off_release(off_release));
